// file: rtl/rtm_mode_ctrl.sv
// Reset-terminal and reserved mode code handler of a 1553 remote terminal
`timescale 1ns/1ns
module rtm_mode_ctrl
  import rtm_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            masterResetPin,  // Asynchronous pin, active high
  // Register port
  input  wire logic [AW-1:0]   regAddr,
  input  wire logic [DW-1:0]   regWrData,
  input  wire logic            regWrStb,
  input  wire logic            regRdStb,
  output logic      [DW-1:0]   regRdData_q,
  // Decoder side
  input  wire logic            msgStb,      // One-cycle message end
  input  wire rtm_msg_t        msg,
  input  wire logic            statusDone,  // Status word sent
  // Status and transmitter control
  output rtm_stat_t            stat_q,
  output logic                 txStatusReq_q,
  // Shared RAM words
  output logic                 dcWr_q,
  output rtm_dcw_t             dcw_q,
  output logic                 miWr_q,
  output rtm_miw_t             miw_q,
  output logic                 ramWr_q,
  output logic      [DW-1:0]   ramAddr_q,
  output logic      [DW-1:0]   ramData_q,
  // Interrupts offered
  output rtm_int_t             intOffer_q
);

  // Handler states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TX, ST_CLEANUP} rtm_state_t;

  rtm_state_t      state_q;     // Current state
  rtm_state_t      state_d;     // Next state
  logic [1:0]      pinSync_q;   // Master reset pin synchroniser
  logic            swRst_q;     // Software reset pulse
  logic            stateRst;    // Any reset of the handler state
  logic [DW-1:0]   cfg_q;       // Configuration
  logic [DW-1:0]   ill_q;       // Illegalization bits
  rtm_stat_t       stat_d;
  rtm_dcw_t        dcw_d;
  rtm_miw_t        miw_d;
  rtm_int_t        int_d;
  logic [DW-1:0]   rdMux;

  // Master reset pin passes two flops before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinSync_q <= 2'h0;
    end else begin
      pinSync_q <= {pinSync_q[0], masterResetPin};
    end
  end

  // Any of the three reset paths returns the handler to its reset state
  assign stateRst = !rst_n || pinSync_q[1] || swRst_q;

  // Register decode
  wire wrCfg  = regWrStb && (regAddr == REG_CFG);
  wire wrIll  = regWrStb && (regAddr == REG_ILL);
  wire wrStat = regWrStb && (regAddr == REG_STAT);
  wire wrDcw  = regWrStb && (regAddr == REG_DCW);

  // Message classification
  wire inGroup  = msg.code[4:3] == CODE_GROUP;      // Codes 8..15
  wire isReset  = msg.code == CODE_RESET;
  wire idle     = state_q == ST_IDLE;
  wire ignore   = !msg.valid || (!msg.tr && cfg_q[CFG_UCI]);
  wire accept   = msgStb && idle && inGroup && !ignore;
  // Transmit codes index the low byte, receive codes the high byte
  wire illBit   = ill_q[{!msg.tr, msg.code[2:0]}];
  // The transmit reset command is always legal
  wire illegal  = !msg.contig && illBit && !(msg.tr && isReset);
  wire rsvTx    = msg.tr && !isReset;
  wire resetCmd = msg.tr && isReset && !msg.contig;

  // Descriptor control word for an accepted message
  always_comb begin
    dcw_d       = dcw_q;
    dcw_d.descAcc   = !resetCmd;
    dcw_d.bcastFlag = msg.contig ? 1'b0 : msg.bcastAddr;
    dcw_d.pingPong  = !dcw_q.pingPong;
  end

  // Message info word for an accepted message
  always_comb begin
    miw_d         = '0;
    // Legal reserved transmit codes without a data word clear the bus side
    miw_d.busSide = (rsvTx && !msg.contig && !illegal) ? 1'b0 : msg.bus;
    miw_d.msgErrFlag = msg.contig || illegal;
    miw_d.illCmd     = illegal;
    miw_d.gap_error_flag  = msg.contig && isReset;
    miw_d.word_count_error_flag  = msg.contig && !isReset;
  end

  // Interrupts offered for an accepted message
  always_comb begin
    int_d       = '0;
    int_d.descAccess = 1'b1;
    // Reserved transmit codes offer no broadcast interrupt
    int_d.bcastRcvd  = !msg.contig && msg.bcastAddr && !rsvTx;
    int_d.msgErr     = msg.contig;
    int_d.illCmd     = illegal;
  end

  // Status bits: message outcome, cleanup, host writes
  always_comb begin
    stat_d = stat_q;
    if (accept) begin
      stat_d.msgErr = msg.contig || illegal;
      if (!msg.contig && msg.bcastAddr) begin
        stat_d.bcastRcvd = 1'b1;
      end
    end else if (state_q == ST_CLEANUP) begin
      stat_d.msgErr    = 1'b0;
      stat_d.busy      = 1'b0;
      stat_d.bcastRcvd = 1'b0;
      stat_d.flagInh   = 1'b0;
      stat_d.shdA  = 1'b0;
      stat_d.shdB  = 1'b0;
    end
    // A host write wins over a clear in the same cycle
    if (wrStat) begin
      stat_d.busy  = regWrData[STAT_BUSY];
      stat_d.flagInh = regWrData[STAT_FLGINH];
      stat_d.shdA  = regWrData[STAT_SHDA];
      stat_d.shdB  = regWrData[STAT_SHDB];
    end
  end

  // Next state of the reset sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept && resetCmd) begin
          // Broadcast sends no status, so clean up at once
          state_d = msg.bcastAddr ? ST_CLEANUP : ST_WAIT_TX;
        end
      end
      ST_WAIT_TX: begin
        if (statusDone) begin
          state_d = ST_CLEANUP;
        end
      end
      ST_CLEANUP: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Read data select; unmapped offsets read zero
  assign rdMux = (regAddr == REG_CFG)  ? cfg_q :
                 (regAddr == REG_ILL)  ? ill_q :
                 (regAddr == REG_STAT) ? {10'h000, stat_q} :
                 (regAddr == REG_DCW)  ? {13'h0000, dcw_q} :
                 (regAddr == REG_MIW)  ? {10'h000, miw_q} : 16'h0000;

  // Software reset pulse; the bit itself never stays set
  always_ff @(posedge clk) begin
    if (stateRst) begin
      swRst_q <= 1'b0;
    end else begin
      swRst_q <= wrCfg && regWrData[CFG_SWRST];
    end
  end

  // Configuration, touched only by the host
  always_ff @(posedge clk) begin
    if (stateRst) begin
      cfg_q <= CFG_RST;
      ill_q <= ILL_RST;
    end else begin
      // The reset command has no path into these
      if (wrCfg) cfg_q <= regWrData & ~(16'h0001 << CFG_SWRST);
      if (wrIll) ill_q <= regWrData;
    end
  end

  // State and status
  always_ff @(posedge clk) begin
    if (stateRst) begin
      state_q <= ST_IDLE;
      stat_q  <= '0;
    end else begin
      state_q <= state_d;
      stat_q  <= stat_d;
    end
  end

  // Descriptor and info words; hardware update wins over host write
  always_ff @(posedge clk) begin
    if (stateRst) begin
      dcw_q <= '0;
      miw_q <= '0;
    end else if (accept) begin
      dcw_q <= dcw_d;
      miw_q <= miw_d;
    end else if (wrDcw) begin
      dcw_q <= regWrData[2:0];
    end
  end

  // One-cycle outputs per accepted message
  always_ff @(posedge clk) begin
    if (stateRst) begin
      dcWr_q        <= 1'b0;
      miWr_q        <= 1'b0;
      intOffer_q    <= '0;
      txStatusReq_q <= 1'b0;
    end else begin
      dcWr_q        <= accept;
      miWr_q        <= accept;
      intOffer_q    <= accept ? int_d : '0;
      // No status for broadcast or contiguous data
      txStatusReq_q <= accept && !msg.contig && !msg.bcastAddr;
    end
  end

  // Built-in-test word clear in shared RAM
  always_ff @(posedge clk) begin
    if (stateRst) begin
      ramWr_q   <= 1'b0;
      ramAddr_q <= 16'h0000;
      ramData_q <= 16'h0000;
    end else begin
      ramWr_q   <= state_q == ST_CLEANUP;
      ramAddr_q <= BIT_WORD_ADDR;
      ramData_q <= BIT_WORD_CLEAR;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData_q <= 16'h0000;
    end else begin
      regRdData_q <= regRdStb ? rdMux : 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (stateRst);

  sequence s_statusSent;
    (state_q == ST_WAIT_TX) && statusDone ##1 (state_q == ST_CLEANUP);
  endsequence

  sequence s_acceptTr0(logic il);
    accept && !msg.tr && !msg.contig && (illBit == il);
  endsequence

  // Accepted reserved transmit code without a trailing data word
  sequence s_acceptRsv(logic il);
    accept && rsvTx && !msg.contig && (illBit == il);
  endsequence

  a_cleanup_status_bits: assert property (
    s_statusSent ##0 !wrStat |=> !stat_q.msgErr && !stat_q.busy && !stat_q.bcastRcvd)
    else $error("status bits not cleared after reset command");

  a_bit_word_clear: assert property (
    s_statusSent |=> ramWr_q && ramAddr_q == 16'h0013 && ramData_q == 16'h0000)
    else $error("built-in-test word not cleared");

  a_shutdown_override: assert property (
    (state_q == ST_CLEANUP) && !wrStat |=> !stat_q.shdA && !stat_q.shdB)
    else $error("transmitter shutdown not overridden");

  a_flag_inhibit_clear: assert property (
    (state_q == ST_CLEANUP) && !wrStat |=> !stat_q.flagInh)
    else $error("terminal flag inhibit not cleared");

  a_config_kept: assert property (
    (state_q == ST_CLEANUP) && !wrCfg && !wrIll |=> $stable(cfg_q) && $stable(ill_q))
    else $error("configuration changed by reset command");

  a_ignore_quiet: assert property (
    msgStb && ignore && !wrStat |=> !dcWr_q && !miWr_q && !txStatusReq_q && intOffer_q == 4'h0
      && $stable(stat_q))
    else $error("ignored message had an effect");

  a_inform_tr0: assert property (
    s_acceptTr0(1'b0) |=> !stat_q.msgErr && !miw_q.msgErrFlag && txStatusReq_q == $past(!msg.bcastAddr))
    else $error("in-form receive code handled wrongly");

  a_inform_desc: assert property (
    s_acceptTr0(1'b0) |=> dcw_q.descAcc && dcw_q.bcastFlag == $past(msg.bcastAddr)
      && intOffer_q.bcastRcvd == $past(msg.bcastAddr))
    else $error("in-form receive code descriptor wrong");

  a_illegal_tr0: assert property (
    s_acceptTr0(1'b1) |=> stat_q.msgErr && miw_q.illCmd && intOffer_q.illCmd && dcw_q.descAcc)
    else $error("illegal receive code handled wrongly");

  // Illegal broadcast receive code offers three of the four interrupts, all but message error
  a_illegal_broadcast_message_flag_int: assert property (
    s_acceptTr0(1'b1) ##0 msg.bcastAddr |=> intOffer_q == 4'hB && miw_q.msgErrFlag)
    else $error("illegal broadcast receive interrupts wrong");

  a_illegal_broadcast_message_flag: assert property (
    accept && !msg.contig && msg.bcastAddr && illegal |=> stat_q.bcastRcvd && stat_q.msgErr
      && !txStatusReq_q)
    else $error("illegal broadcast answered with status");

  a_broadcast_message_flag_no_status: assert property (
    accept && msg.bcastAddr && !msg.contig |=> stat_q.bcastRcvd && !txStatusReq_q)
    else $error("broadcast answered with status");

  a_invalid_ignored: assert property (
    msgStb && !msg.valid |=> !dcWr_q && !miWr_q && !txStatusReq_q)
    else $error("invalid command word answered");

  a_contig_gap: assert property (
    accept && msg.contig && isReset |=> stat_q.msgErr && miw_q.gap_error_flag && !miw_q.word_count_error_flag
      && !txStatusReq_q && intOffer_q == 4'h5 && !dcw_q.bcastFlag)
    else $error("reset command with data word handled wrongly");

  a_contig_wct: assert property (
    accept && msg.contig && !isReset |=> miw_q.word_count_error_flag && !miw_q.gap_error_flag && !txStatusReq_q)
    else $error("reserved code with data word handled wrongly");

  a_reserved_legal: assert property (
    s_acceptRsv(1'b0) |=> !miw_q.busSide && !stat_q.msgErr
      && intOffer_q == 4'h1)
    else $error("legal reserved code handled wrongly");

  // Bus side follows the command on an illegal reserved code
  a_reserved_illegal: assert property (
    s_acceptRsv(1'b1) |=> stat_q.msgErr && miw_q.illCmd && miw_q.msgErrFlag
      && miw_q.busSide == $past(msg.bus) && intOffer_q == 4'h9)
    else $error("illegal reserved code handled wrongly");

  // Reset command itself leaves the descriptor unaccessed
  a_reset_response: assert property (
    accept && resetCmd |=> !stat_q.msgErr && !dcw_q.descAcc
      && txStatusReq_q == $past(!msg.bcastAddr))
    else $error("reset command response wrong");

  a_pingpong_toggle: assert property (
    accept |=> dcw_q.pingPong != $past(dcw_q.pingPong) && dcWr_q && miWr_q)
    else $error("ping-pong bit did not toggle");

endmodule

// file: rtl/rtm_pkg.sv
// Constants and types for the reset-terminal and reserved mode code handler
package rtm_pkg;

  // Register port geometry
  localparam int DW = 16;
  localparam int AW = 4;

  // Register offsets
  localparam logic [AW-1:0] REG_CFG  = 4'h0;  // Configuration
  localparam logic [AW-1:0] REG_ILL  = 4'h1;  // Illegalization bits, codes 8..15
  localparam logic [AW-1:0] REG_STAT = 4'h2;  // Internal status bits
  localparam logic [AW-1:0] REG_DCW  = 4'h3;  // Descriptor control bits
  localparam logic [AW-1:0] REG_MIW  = 4'h4;  // Last message info bits

  // Configuration field positions
  localparam int CFG_UCI  = 0;  // Undefined code invalid
  localparam int CFG_SWRST = 1;  // Software reset, self clearing

  // Status field positions
  localparam int STAT_BUSY  = 1;
  localparam int STAT_FLGINH = 3;
  localparam int STAT_SHDA  = 4;
  localparam int STAT_SHDB  = 5;

  // Values after reset
  localparam logic [DW-1:0] CFG_RST = 16'h0000;
  localparam logic [DW-1:0] ILL_RST = 16'h0000;

  // Mode codes handled here
  localparam logic [4:0] CODE_RESET = 5'h08;
  localparam logic [1:0] CODE_GROUP = 2'h1;   // Upper bits of codes 8..15

  // Built-in-test word in shared RAM and its cleared value
  localparam logic [DW-1:0] BIT_WORD_ADDR  = 16'h0013;
  localparam logic [DW-1:0] BIT_WORD_CLEAR = 16'h0000;

  // Decoded mode code message, reported once at message end
  typedef struct packed {
    logic       valid;   // Command word valid
    logic       tr;      // Transmit/receive bit
    logic       bcastAddr;  // Broadcast address
    logic       bus;     // Bus the command came on
    logic       contig;  // A data word followed contiguously
    logic [4:0] code;    // Mode code
  } rtm_msg_t;

  // Internal status bits, bit 5 downward
  typedef struct packed {
    logic shdB;   // Transmitter B shut down
    logic shdA;   // Transmitter A shut down
    logic flagInh;    // Terminal flag inhibited
    logic bcastRcvd;  // Broadcast received status
    logic busy;       // Busy status
    logic msgErr;     // Message error status
  } rtm_stat_t;

  // Descriptor control word bits
  typedef struct packed {
    logic pingPong;   // Ping-pong select
    logic bcastFlag;  // Broadcast message flag
    logic descAcc;    // Descriptor accessed flag
  } rtm_dcw_t;

  // Message info word bits
  typedef struct packed {
    logic word_count_error_flag;   // Word count error flag
    logic gap_error_flag;   // Gap error flag
    logic termToTerm;  // Terminal-to-terminal flag
    logic illCmd;      // Illegal command flag
    logic msgErrFlag;  // Message error flag
    logic busSide;  // Bus side flag
  } rtm_miw_t;

  // Interrupts offered for one message
  typedef struct packed {
    logic illCmd;      // Illegal command
    logic msgErr;      // Message error
    logic bcastRcvd;   // Broadcast received
    logic descAccess;  // Descriptor access
  } rtm_int_t;

endpackage

// file: verification/rtm_bc_model.sv
// Bus controller and encoder model facing the mode code handler
`timescale 1ns/1ns
module rtm_bc_model
  import rtm_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // Device side
  input  wire logic     txStatusReq_q,
  output rtm_msg_t      msg,
  output logic          msgStb,
  output logic          statusDone
);
  int statusDelay = 1;  // Cycles the encoder needs for a status word

  // Idle at time zero
  initial begin
    msg        = '0;
    msgStb     = 1'h0;
    statusDone = 1'h0;
  end

  // One message end; fields inverted afterwards so stale values never match
  task automatic send(input rtm_msg_t m);
    @(posedge clk);
    msgStb <= 1'h1;
    msg    <= m;
    @(posedge clk);
    msgStb <= 1'h0;
    msg    <= ~m;
    #1;
  endtask

  // Encoder answers a status request promptly or slowly
  always @(posedge clk) begin
    if (rst_n && txStatusReq_q) begin
      repeat (statusDelay) @(posedge clk);
      statusDone <= 1'h1;
      @(posedge clk);
      statusDone <= 1'h0;
    end
  end
endmodule

// file: verification/rtm_mode_ctrl_tb.sv
// Self-checking bench for the reset-terminal and reserved mode code handler
`timescale 1ns/1ns
module rtm_mode_ctrl_tb
  import rtm_pkg::*;
;
  // Design ports
  logic           clk, rst_n, masterResetPin, regWrStb, regRdStb, msgStb, statusDone;
  logic [AW-1:0]  regAddr;
  logic [DW-1:0]  regWrData, regRdData_q, ramAddr_q, ramData_q;
  logic           txStatusReq_q, dcWr_q, miWr_q, ramWr_q;
  rtm_msg_t       msg;
  rtm_stat_t      stat_q;
  rtm_dcw_t       dcw_q;
  rtm_miw_t       miw_q;
  rtm_int_t       intOffer_q;
  // Bench state
  int             failures, cmp_count;
  logic           pingExp, rcvdExp, ill, bus;
  logic [15:0]    illTab = 16'h5A3C;  // Mixed legal and illegal codes

  rtm_mode_ctrl dut (.clk, .rst_n, .masterResetPin, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData_q, .msgStb, .msg, .statusDone, .stat_q, .txStatusReq_q, .dcWr_q, .dcw_q,
    .miWr_q, .miw_q, .ramWr_q, .ramAddr_q, .ramData_q, .intOffer_q);

  rtm_bc_model bc (.clk, .rst_n, .txStatusReq_q, .msg, .msgStb, .statusDone);

  // Free running clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic results();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'h1;
    @(posedge clk);
    regWrStb  <= 1'h0;
  endtask

  // One-cycle register read, data taken in the following cycle only
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    regAddr  <= a;
    regRdStb <= 1'h1;
    @(posedge clk);
    regRdStb <= 1'h0;
    #1;
    d = regRdData_q;
  endtask

  // Bounded wait for the test word clear that closes a reset sequence
  task automatic waitRam();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (ramWr_q !== 1'h1 && i < 80);
  endtask

  function automatic rtm_msg_t mk(input logic v, t, b, u, g, input logic [4:0] c);
    mk = '{v, t, b, u, g, c};
  endfunction

  // Watchdog, far beyond the expected run of about 250 cycles
  initial begin
    #100000;
    failures++;
    results();
  end

  // Main sequence
  initial begin
    logic [15:0] d;
    {rst_n, masterResetPin, regWrStb, regRdStb} = 4'h0;
    regAddr   = '0;
    regWrData = '0;
    failures  = 0;
    cmp_count = 0;
    pingExp   = 1'h0;
    rcvdExp   = 1'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;

    // Reset command with host state preloaded
    wr(REG_ILL, illTab);
    wr(REG_CFG, 16'h0001);
    wr(REG_STAT, 16'h003A);
    bc.send(mk(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, CODE_RESET));
    pingExp = ~pingExp;
    check(16'({txStatusReq_q, stat_q}), 16'h007A);
    check(16'({dcw_q, miw_q, intOffer_q}), {3'h0, pingExp, 12'h011});
    waitRam();
    check(16'({ramWr_q, stat_q}), 16'h0040);
    check(ramAddr_q, BIT_WORD_ADDR);
    check(ramData_q, 16'h0000);
    rd(REG_CFG, d);
    check(d, 16'h0001);
    rd(REG_ILL, d);
    check(d, illTab);
    $display("Reset command test done");

    // Invalid word and undefined receive code are ignored
    for (int k = 0; k < 2; k++) begin
      bc.send(mk(k[0], 1'h0, 1'h0, 1'h0, 1'h0, 5'h09));
      check(16'({txStatusReq_q, dcWr_q, miWr_q, intOffer_q}), 16'h0000);
      check(16'({dcw_q.pingPong, stat_q}), {9'h0, pingExp, 6'h00});
    end
    $display("Ignored message test done");

    // Every code 8..15, both directions except transmit code 8, broadcast or not
    wr(REG_CFG, 16'h0000);
    for (int c = 8; c < 16; c++) begin
      for (int t = 0; t < 2; t++) begin
        for (int b = 0; b < 2; b++) begin
          if (t == 1 && c == 8) continue;
          ill = illTab[c - 8 + (t == 0 ? 8 : 0)];
          bus = c[0] ^ b[0];
          bc.send(mk(1'h1, t[0], b[0], bus, 1'h0, c[4:0]));
          pingExp = ~pingExp;
          rcvdExp = rcvdExp | b[0];
          check(16'({dcWr_q, miWr_q, txStatusReq_q}), {13'h0, 2'h3, ~b[0]});
          check(16'({stat_q.bcastRcvd, stat_q.msgErr}), {14'h0, rcvdExp, ill});
          check(16'(dcw_q), {13'h0, pingExp, b[0], 1'h1});
          check(16'(miw_q), {13'h0, ill, ill, (t == 1 && !ill) ? 1'h0 : bus});
          check(16'(intOffer_q), {12'h0, ill, 1'h0, b[0] & (t == 0), 1'h1});
          repeat (3) @(posedge clk);
        end
      end
    end
    $display("Mode code table test done");

    // Contiguous data word after reset and reserved codes
    for (int k = 0; k < 2; k++) begin
      bc.send(mk(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, k ? 5'h0C : CODE_RESET));
      pingExp = ~pingExp;
      check(16'({txStatusReq_q, stat_q.msgErr}), 16'h0001);
      check(16'(dcw_q), {13'h0, pingExp, 2'h1});
      check(16'(miw_q), k ? 16'h0023 : 16'h0013);
      check(16'(intOffer_q), 16'h0005);
      repeat (3) @(posedge clk);
    end
    $display("Contiguous word test done");

    // Broadcast reset: no status, then cleanup
    bc.send(mk(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, CODE_RESET));
    check(16'({txStatusReq_q, stat_q.bcastRcvd}), 16'h0001);
    waitRam();
    check(16'({ramWr_q, stat_q}), 16'h0040);
    $display("Broadcast reset test done");

    // Slow encoder: status clears only after the word went out
    wr(REG_STAT, 16'h0002);
    bc.statusDelay = 20;
    bc.send(mk(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, CODE_RESET));
    bc.send(mk(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 5'h09));
    check(16'({dcWr_q, stat_q.busy}), 16'h0001);
    waitRam();
    check(16'({ramWr_q, stat_q}), 16'h0040);
    $display("Slow status test done");

    // Host applies the software reset bit
    wr(REG_CFG, 16'h0003);
    repeat (2) @(posedge clk);
    rd(REG_CFG, d);
    check(d, 16'h0000);
    rd(REG_ILL, d);
    check(d, 16'h0000);
    $display("Software reset test done");

    // Host finishes with the master reset pin
    wr(REG_ILL, 16'h00FF);
    wr(REG_STAT, 16'h0002);
    masterResetPin <= 1'h1;
    repeat (4) @(posedge clk);
    masterResetPin <= 1'h0;
    repeat (4) @(posedge clk);
    rd(REG_ILL, d);
    check(16'({d[7:0], stat_q}), 16'h0000);
    $display("Master reset test done");
    results();
  end
endmodule
